/* File: dv/trf_replicator_asserts.sv */
// Checker of filtering, handshake holding, overrides and register readback.
`timescale 1ns/1ps
module trf_replicator_asserts
    import trf_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // Trace handshakes.
    input wire logic upstream_ready_out,
    input wire logic downstream0_valid_out,
    input wire logic downstream0_ready_in,
    input wire logic [TRF_ID_W-1:0] downstream0_id_out,
    input wire logic downstream1_valid_out,
    input wire logic downstream1_ready_in,
    input wire logic [TRF_ID_W-1:0] downstream1_id_out
);
    logic wr, rd, mode;
    logic [4:0] drv;
    logic [7:0] f0, f1;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && !penable && !pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Shadow copies of the control fields, so outputs can be tied to what software wrote.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {mode, drv, f0, f1} <= '0;
        end else if (wr) begin
            case (paddr)
                TRF_OFS_MODE_CTRL: mode <= pwdata[0];
                TRF_OFS_HS_DRIVE: drv <= pwdata[4:0] & 5'h15;
                TRF_OFS_PORT0_FILTER: f0 <= pwdata[7:0];
                TRF_OFS_PORT1_FILTER: f1 <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    AST_DROP0: assert property (
        downstream0_valid_out && !mode |-> !f0[downstream0_id_out[6:4]]) else $error("Leak on 0.");
    AST_DROP1: assert property (
        downstream1_valid_out && !mode |-> !f1[downstream1_id_out[6:4]]) else $error("Leak on 1.");
    AST_HOLD0: assert property (downstream0_valid_out && !downstream0_ready_in && !mode && !wr
        |=> downstream0_valid_out && $stable(downstream0_id_out)) else $error("Output 0 let go.");
    AST_HOLD1: assert property (downstream1_valid_out && !downstream1_ready_in && !mode && !wr
        |=> downstream1_valid_out && $stable(downstream1_id_out)) else $error("Output 1 let go.");
    AST_FORCE_READY: assert property (mode |-> upstream_ready_out == drv[4])
        else $error("Ready not forced.");
    AST_FORCE_VALID: assert property (
        mode |-> {downstream1_valid_out, downstream0_valid_out} == {drv[2], drv[0]})
        else $error("Valids not forced.");
    AST_DRIVE_READ: assert property (rd && paddr == TRF_OFS_HS_DRIVE
        |=> (prdata & 32'h15) == {27'h0, drv}) else $error("Drive readback wrong.");
    AST_TAG_SET_READ: assert property (rd && paddr == TRF_OFS_TAG_SET
        |=> prdata == 32'h0000000f) else $error("Tag set read wrong.");
    AST_OBSERVE_IDLE: assert property (rd && paddr == TRF_OFS_HS_OBSERVE && !mode
        |=> prdata == 32'h0) else $error("Observe live outside mode.");
    cover property (downstream0_valid_out && downstream0_ready_in && downstream1_valid_out);
    cover property (!upstream_ready_out && !mode);
    cover property (mode && upstream_ready_out);
endmodule // trf_replicator_asserts
bind trf_replicator trf_replicator_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .upstream_ready_out(upstream_ready_out),
    .downstream0_valid_out(downstream0_valid_out), .downstream0_ready_in(downstream0_ready_in),
    .downstream0_id_out(downstream0_id_out), .downstream1_valid_out(downstream1_valid_out),
    .downstream1_ready_in(downstream1_ready_in), .downstream1_id_out(downstream1_id_out));

/* File: dv/trf_replicator_tb.sv */
// Self-checking bench of the replicator register port and trace paths.
`timescale 1ns/1ps
module trf_replicator_tb
    import trf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic ur, v0, v1, r0, r1;
    logic uv = 1'b0;
    logic [6:0] uid = 7'h00;
    logic [6:0] i0, i1;
    logic [31:0] d0, d1;
    logic [1:0] b0, b1;
    logic prdy, perr;
    logic [7:0] n0, n1;
    logic [3:0] auth = 4'h0;
    logic [1:0] hold = 2'h0;
    logic slow = 1'b0;
    logic [7:0] fa = 8'ha1;
    logic [7:0] fb = 8'h26;
    int failures = 0;
    int cmp_count = 0;
    int e0 = 3;
    int e1 = 3;
    logic [11:0] ofs [10] = '{TRF_OFS_PORT0_FILTER, TRF_OFS_PORT1_FILTER, TRF_OFS_HS_DRIVE,
        TRF_OFS_HS_OBSERVE, TRF_OFS_MODE_CTRL, TRF_OFS_TAG_SET, TRF_OFS_TAG_CLEAR,
        TRF_OFS_AFFINITY_LOW, TRF_OFS_AFFINITY_HIGH, 12'h100};
    logic [11:0] perm [4] = '{12'h0aa, 12'hfff, 12'h4ae, 12'h9ef};
    logic [6:0] ids [8] = '{7'h05, 7'h1f, 7'h2a, 7'h55, 7'h7e, 7'h30, 7'h0f, 7'h6b};
    logic [4:0] drv [3] = '{5'h14, 5'h01, 5'h10};
    trf_replicator dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(3'h0), .prdata(prdata),
        .pready(prdy), .pslverr(perr), .upstream_valid_in(uv), .upstream_ready_out(ur),
        .upstream_id_in(uid), .upstream_data_in({25'h0, uid}), .upstream_bytes_in(uid[1:0]),
        .downstream0_valid_out(v0), .downstream0_ready_in(r0), .downstream0_id_out(i0),
        .downstream0_data_out(d0), .downstream0_bytes_out(b0), .downstream1_valid_out(v1),
        .downstream1_ready_in(r1), .downstream1_id_out(i1), .downstream1_data_out(d1),
        .downstream1_bytes_out(b1), .invasive_enable_in(auth[3]), .noninvasive_enable_in(auth[2]),
        .secure_invasive_enable_in(auth[1]), .secure_noninvasive_enable_in(auth[0]));
    trf_sink_model sink0 (.sys_clk(sys_clk), .sys_rst(sys_rst), .hold_off(hold[0]),
        .slow(slow), .valid(v0), .ready(r0), .seen(n0));
    trf_sink_model sink1 (.sys_clk(sys_clk), .sys_rst(sys_rst), .hold_off(hold[1]),
        .slow(1'b0), .valid(v1), .ready(r1), .seen(n1));
    // Free-running clock of 100 ns period.
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One register access; on reads d is the expected value.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
        @(negedge sys_clk);
        penable = 1'b1;
        @(posedge sys_clk);
        chk("response", 32'h1, {30'h0, perr, prdy});
        if (!w) chk($sformatf("reg %h", a), d, prdata);
        @(negedge sys_clk);
        {psel, penable} = 2'b00;
    endtask
    // Offers one word and holds it until the rising edge that takes it.
    task automatic send(input logic [6:0] i);
        @(negedge sys_clk);
        {uv, uid} = {1'b1, i};
        for (int n = 0; n < 100 && ur !== 1'b1; n++) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    // Every word a sink takes must carry the data and byte count sent with its ID.
    always @(negedge sys_clk) begin
        if (v0 && r0) chk("word 0", {23'h0, i0, i0[1:0]}, {d0[29:0], b0});
        if (v1 && r1) chk("word 1", {23'h0, i1, i1[1:0]}, {d1[29:0], b1});
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence: reset values, permission, tags, stall, filtering, integration.
    initial begin
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        foreach (ofs[k]) apb(1'b0, ofs[k], (k == 5) ? 32'hf : 32'h0);
        foreach (perm[k]) begin
            auth = perm[k][11:8];
            apb(1'b0, TRF_OFS_PERMISSION, {24'h0, perm[k][7:0]});
        end
        apb(1'b1, TRF_OFS_TAG_SET, 32'h5);
        apb(1'b0, TRF_OFS_TAG_CLEAR, 32'h5);
        apb(1'b1, TRF_OFS_TAG_CLEAR, 32'h4);
        apb(1'b1, TRF_OFS_TAG_SET, 32'h8);
        apb(1'b0, TRF_OFS_TAG_CLEAR, 32'h9);
        apb(1'b0, TRF_OFS_TAG_SET, 32'hf);
        apb(1'b1, TRF_OFS_AFFINITY_HIGH, 32'hffffffff);
        apb(1'b0, TRF_OFS_AFFINITY_HIGH, 32'h0);
        hold = 2'h3;
        send(7'h11);
        send(7'h12);
        @(negedge sys_clk);
        chk("upstream ready", 32'h0, ur);
        fork
            send(7'h13);
            begin
                repeat (3) @(negedge sys_clk);
                hold = 2'h0;
            end
        join
        @(negedge sys_clk);
        uv = 1'b0;
        apb(1'b1, TRF_OFS_PORT0_FILTER, {24'h0, fa});
        pstrb = 4'he;
        apb(1'b1, TRF_OFS_PORT0_FILTER, 32'hff);
        pstrb = 4'hf;
        apb(1'b0, TRF_OFS_PORT0_FILTER, {24'h0, fa});
        apb(1'b1, TRF_OFS_PORT1_FILTER, {24'h0, fb});
        apb(1'b0, TRF_OFS_PORT1_FILTER, {24'h0, fb});
        chk("sink counts", 32'h0303, {n0, n1});
        slow = 1'b1;
        foreach (ids[k]) begin
            send(ids[k]);
            e0 += int'(!fa[ids[k][6:4]]);
            e1 += int'(!fb[ids[k][6:4]]);
        end
        @(negedge sys_clk);
        uv = 1'b0;
        repeat (30) @(negedge sys_clk);
        chk("sink counts", {e0[7:0], e1[7:0]}, {n0, n1});
        slow = 1'b0;
        apb(1'b1, TRF_OFS_MODE_CTRL, 32'h1);
        apb(1'b0, TRF_OFS_MODE_CTRL, 32'h1);
        foreach (drv[k]) begin
            apb(1'b1, TRF_OFS_HS_DRIVE, {27'h0, drv[k]});
            @(negedge sys_clk);
            chk("forced", {drv[k][4], drv[k][2], drv[k][0]}, {ur, v1, v0});
            apb(1'b0, TRF_OFS_HS_DRIVE, {27'h0, drv[k]});
        end
        uv = 1'b1;
        hold = 2'h1;
        apb(1'b0, TRF_OFS_HS_OBSERVE, 32'h0a);
        hold = 2'h2;
        apb(1'b0, TRF_OFS_HS_OBSERVE, 32'h09);
        uv = 1'b0;
        apb(1'b1, TRF_OFS_MODE_CTRL, 32'h0);
        apb(1'b0, TRF_OFS_HS_OBSERVE, 32'h0);
        complete_run();
    end
    // Cuts a hung run short.
    initial begin
        repeat (4000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule // trf_replicator_tb

/* File: dv/trf_sink_model.sv */
// Behavioural trace sink that stalls on request and counts the words it accepts.
`timescale 1ns/1ps
module trf_sink_model
    import trf_pkg::*;
(
    // Clock, reset and stall controls.
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hold_off,
    input wire logic slow,
    // Trace handshake and count of accepted words.
    input wire logic valid,
    output logic ready,
    output logic [7:0] seen
);
    logic [1:0] phase;
    // Ready moves just after the rising edge; slow mode accepts one cycle in four.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {phase, ready, seen} <= '0;
        end else begin
            phase <= phase + 2'h1;
            ready <= !hold_off && (!slow || phase == 2'h0);
            seen <= seen + {7'h0, valid && ready};
        end
    end
endmodule // trf_sink_model

/* File: rtl/trf_pkg.sv */
// Package of register offsets, field positions and reset values for the trace replicator.
package trf_pkg;
    // Register byte offsets on the register port.
    localparam logic [11:0] TRF_OFS_PORT0_FILTER = 12'h000;
    localparam logic [11:0] TRF_OFS_PORT1_FILTER = 12'h004;
    localparam logic [11:0] TRF_OFS_HS_DRIVE = 12'hef8;
    localparam logic [11:0] TRF_OFS_HS_OBSERVE = 12'hefc;
    localparam logic [11:0] TRF_OFS_MODE_CTRL = 12'hf00;
    localparam logic [11:0] TRF_OFS_TAG_SET = 12'hfa0;
    localparam logic [11:0] TRF_OFS_TAG_CLEAR = 12'hfa4;
    localparam logic [11:0] TRF_OFS_AFFINITY_LOW = 12'hfa8;
    localparam logic [11:0] TRF_OFS_AFFINITY_HIGH = 12'hfac;
    localparam logic [11:0] TRF_OFS_PERMISSION = 12'hfb8;

    // Widths of the trace bus and of register fields.
    localparam int TRF_ID_W = 7;
    localparam int TRF_DATA_W = 32;
    localparam int TRF_BYTES_W = 2;
    localparam int TRF_GROUPS = 8;
    localparam int TRF_TAG_W = 4;
    localparam int TRF_PORTS = 2;

    // Field positions in the integration handshake registers.
    localparam int TRF_FORCE_UPSTREAM_READY_POS = 4;
    localparam int TRF_FORCE_DOWNSTREAM1_VALID_POS = 2;
    localparam int TRF_FORCE_DOWNSTREAM0_VALID_POS = 0;
    localparam int TRF_OBSERVE_UPSTREAM_VALID_POS = 3;
    localparam int TRF_OBSERVE_DOWNSTREAM1_READY_POS = 1;
    localparam int TRF_OBSERVE_DOWNSTREAM0_READY_POS = 0;
    localparam int TRF_MODE_ENABLE_POS = 0;

    // Reset values.
    localparam logic [TRF_GROUPS-1:0] TRF_FILTER_RESET = 8'h00;
    localparam logic [4:0] TRF_HS_DRIVE_RESET = 5'h00;
    localparam logic TRF_MODE_RESET = 1'b0;
    localparam logic [TRF_TAG_W-1:0] TRF_TAG_RESET = 4'h0;
    localparam logic [TRF_TAG_W-1:0] TRF_TAG_IMPLEMENTED = 4'hf;
    localparam logic [7:0] TRF_PERMISSION_RESET = 8'h00;

    // Two-bit permission status encodings.
    localparam logic [1:0] TRF_AUTH_ABSENT = 2'h0;
    localparam logic [1:0] TRF_AUTH_DISABLED = 2'h2;
    localparam logic [1:0] TRF_AUTH_ENABLED = 2'h3;

    // Depth of the input buffer.
    localparam int TRF_BUF_DEPTH = 2;
endpackage

/* File: rtl/trf_replicator.sv */
// Trace-bus replicator with per-output source ID group filtering and its register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Output 0 forwards IDs whose group bit is 0.
// - Independent group filter for output 1.
// - Filter bit n covers IDs 0xn0 to 0xnF.
// - Set bit discards that group on that output.
// - Both filters reset to zero, pass everything.
// - Handshake drive register reads back bits 4, 2 and 0 of last write; bits 3 and 1 read zero.
// - Drive bit 4 forces upstream ready level.
// - Drive bits 2 and 0 force downstream valids.
// - Observe bit 3 shows live upstream valid.
// - Observe bits 1, 0 show downstream readies.
// - Mode bit 0 enables integration mode, resets 0.
// - Tag-set write sets bits written as one.
// - Tag-set read returns all four implemented ones.
// - Tag-clear write clears ones; read returns tag.
// - Tag resets zero, never affects the hardware.
// - Both affinity words read as zero.
// - Permission status mirrors authentication inputs, resets zero.
// - Fields: 0 absent, 2 disabled, 3 enabled.

// Overview of the data path.
// Every upstream word lands in a two-entry buffer before it is shown downstream.
// Both outputs present the same buffer head at the same time.
// Each output keeps a done flag once it has taken its copy of the head.
// The head retires only when both outputs have taken or filtered it.
// A word that both outputs filter retires one cycle after it is taken.
// The buffer costs one cycle of latency from upstream to downstream.
// In return a stall on one output never drops a word from the other.

// Overview of filtering.
// The upper three bits of the seven-bit ID pick one of eight groups.
// Each output owns an eight-bit mask with one bit per group.
// A set bit hides that group on that output only.
// A mask change takes effect at once, even for a half-sent head word.
// Software that needs a clean switch should first stop the source.

// Overview of integration mode.
// While the mode bit is set, no trace word moves through the block.
// The upstream ready and both downstream valids then follow the drive bits.
// The observe register then shows the live handshake inputs.
// Outside the mode the observe register reads as zero.
// Leaving the mode returns the handshakes to the buffer logic.
// Words left in the buffer are then offered again as normal.

// Overview of the register port.
// The port answers in the access phase with no wait state and no error.
// Read data is captured in the setup phase and held until the next read.
// Only the low byte strobe matters, since every field sits in byte zero.
// Writes to read-only or unmapped offsets are ignored without an error.
// The protection bits are accepted and ignored.

module trf_replicator
    import trf_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB4 register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Upstream trace input.
    input wire logic upstream_valid_in,
    output logic upstream_ready_out,
    input wire logic [TRF_ID_W-1:0] upstream_id_in,
    input wire logic [TRF_DATA_W-1:0] upstream_data_in,
    input wire logic [TRF_BYTES_W-1:0] upstream_bytes_in,
    // Downstream trace output 0.
    output logic downstream0_valid_out,
    input wire logic downstream0_ready_in,
    output logic [TRF_ID_W-1:0] downstream0_id_out,
    output logic [TRF_DATA_W-1:0] downstream0_data_out,
    output logic [TRF_BYTES_W-1:0] downstream0_bytes_out,
    // Downstream trace output 1.
    output logic downstream1_valid_out,
    input wire logic downstream1_ready_in,
    output logic [TRF_ID_W-1:0] downstream1_id_out,
    output logic [TRF_DATA_W-1:0] downstream1_data_out,
    output logic [TRF_BYTES_W-1:0] downstream1_bytes_out,
    // Authentication control inputs.
    input wire logic invasive_enable_in,
    input wire logic noninvasive_enable_in,
    input wire logic secure_invasive_enable_in,
    input wire logic secure_noninvasive_enable_in
);
    localparam int ENTRY_W = TRF_ID_W + TRF_BYTES_W + TRF_DATA_W;

    // Register state.
    logic [TRF_GROUPS-1:0] port_filter [TRF_PORTS];
    logic [4:0] hs_drive;
    logic mode_enable;
    logic [TRF_TAG_W-1:0] ownership_tag;
    logic [7:0] permission_status;

    // Buffer state.
    logic [ENTRY_W-1:0] buf_mem [TRF_BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] buf_count;
    logic [ENTRY_W-1:0] head;
    logic [TRF_ID_W-1:0] head_id;
    logic head_valid;
    logic buf_full;
    logic push;
    logic pop;

    // Per-output handshake terms.
    logic [TRF_PORTS-1:0] port_ready;
    logic [TRF_PORTS-1:0] port_drop;
    logic [TRF_PORTS-1:0] port_done;
    logic [TRF_PORTS-1:0] port_need;
    logic [TRF_PORTS-1:0] port_accept;
    logic [TRF_PORTS-1:0] port_settled;
    logic [TRF_PORTS-1:0] port_force;

    // Bus phase decode.
    logic wr_access;
    logic wr_low;
    logic rd_setup;
    logic [31:0] next_prdata;

    // The register port answers every access with zero wait states and no error.
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_access = psel && penable && pwrite;
    assign wr_low = wr_access && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;

    // Filter registers, one per output.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_filter[0] <= TRF_FILTER_RESET;
            port_filter[1] <= TRF_FILTER_RESET;
        end else if (wr_low && paddr == TRF_OFS_PORT0_FILTER) begin
            port_filter[0] <= pwdata[TRF_GROUPS-1:0];
        end else if (wr_low && paddr == TRF_OFS_PORT1_FILTER) begin
            port_filter[1] <= pwdata[TRF_GROUPS-1:0];
        end
    end

    // Integration handshake drive register keeps bits 4, 2 and 0 of what was written; bits 3 and 1 stay zero.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hs_drive <= TRF_HS_DRIVE_RESET;
        end else if (wr_low && paddr == TRF_OFS_HS_DRIVE) begin
            hs_drive[TRF_FORCE_UPSTREAM_READY_POS] <=
                pwdata[TRF_FORCE_UPSTREAM_READY_POS];
            hs_drive[TRF_FORCE_DOWNSTREAM1_VALID_POS] <=
                pwdata[TRF_FORCE_DOWNSTREAM1_VALID_POS];
            hs_drive[TRF_FORCE_DOWNSTREAM0_VALID_POS] <=
                pwdata[TRF_FORCE_DOWNSTREAM0_VALID_POS];
        end
    end

    // Integration mode enable.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_enable <= TRF_MODE_RESET;
        end else if (wr_low && paddr == TRF_OFS_MODE_CTRL) begin
            mode_enable <= pwdata[TRF_MODE_ENABLE_POS];
        end
    end

    // Ownership tag: set and clear by writing ones; it feeds nothing but read data.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ownership_tag <= TRF_TAG_RESET;
        end else if (wr_low && paddr == TRF_OFS_TAG_SET) begin
            ownership_tag <= ownership_tag | pwdata[TRF_TAG_W-1:0];
        end else if (wr_low && paddr == TRF_OFS_TAG_CLEAR) begin
            ownership_tag <= ownership_tag & ~pwdata[TRF_TAG_W-1:0];
        end
    end

    // The permission fields never report the reserved code; absent shows only from reset until the first clock edge after it.
    // Every implemented field shows either disabled or enabled.
    // The hypervisor fields stay at zero, since no such inputs exist.
    // The one-cycle delay keeps the read path short.

    // Permission status follows the authentication inputs one cycle later.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            permission_status <= TRF_PERMISSION_RESET;
        end else begin
            permission_status[1:0] <= invasive_enable_in ?
                TRF_AUTH_ENABLED : TRF_AUTH_DISABLED;
            permission_status[3:2] <= (invasive_enable_in || noninvasive_enable_in) ?
                TRF_AUTH_ENABLED : TRF_AUTH_DISABLED;
            permission_status[5:4] <= (invasive_enable_in && secure_invasive_enable_in) ?
                TRF_AUTH_ENABLED : TRF_AUTH_DISABLED;
            permission_status[7:6] <= ((invasive_enable_in || noninvasive_enable_in) &&
                (secure_invasive_enable_in || secure_noninvasive_enable_in)) ?
                TRF_AUTH_ENABLED : TRF_AUTH_DISABLED;
        end
    end

    // The read multiplexer is a plain priority chain on the byte offset.
    // Bits above each field read as zero.
    // The tag-set offset returns the mask of implemented tag bits.
    // The tag-clear offset returns the tag itself.
    // The observe offset reads live pins, so its value may move between reads.

    // Read data is chosen in the setup phase and held through the access phase.
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == TRF_OFS_PORT0_FILTER) begin
            next_prdata[TRF_GROUPS-1:0] = port_filter[0];
        end else if (paddr == TRF_OFS_PORT1_FILTER) begin
            next_prdata[TRF_GROUPS-1:0] = port_filter[1];
        end else if (paddr == TRF_OFS_HS_DRIVE) begin
            next_prdata[4:0] = hs_drive;
        end else if (paddr == TRF_OFS_HS_OBSERVE) begin
            if (mode_enable) begin
                next_prdata[TRF_OBSERVE_UPSTREAM_VALID_POS] = upstream_valid_in;
                next_prdata[TRF_OBSERVE_DOWNSTREAM1_READY_POS] = downstream1_ready_in;
                next_prdata[TRF_OBSERVE_DOWNSTREAM0_READY_POS] = downstream0_ready_in;
            end
        end else if (paddr == TRF_OFS_MODE_CTRL) begin
            next_prdata[TRF_MODE_ENABLE_POS] = mode_enable;
        end else if (paddr == TRF_OFS_TAG_SET) begin
            next_prdata[TRF_TAG_W-1:0] = TRF_TAG_IMPLEMENTED;
        end else if (paddr == TRF_OFS_TAG_CLEAR) begin
            next_prdata[TRF_TAG_W-1:0] = ownership_tag;
        end else if (paddr == TRF_OFS_AFFINITY_LOW || paddr == TRF_OFS_AFFINITY_HIGH) begin
            next_prdata = 32'h0000_0000;
        end else if (paddr == TRF_OFS_PERMISSION) begin
            next_prdata[7:0] = permission_status;
        end
    end

    // Read data register.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // The buffer is a small ring of two entries with one-bit pointers.
    // The occupancy counter needs two bits to tell empty from full.
    // Upstream ready depends only on the count and the mode drive bit, never on downstream ready.
    // That keeps a combinational path from downstream to upstream out of the block.
    // The price is that a full buffer waits one cycle after a pop to refill.
    // Entries hold ID, byte count and data packed side by side.

    // Two-entry input buffer; a stall downstream fills it and drops upstream ready.
    assign buf_full = (buf_count == 2'(TRF_BUF_DEPTH));
    assign head_valid = (buf_count != 2'h0);
    assign head = buf_mem[rd_ptr];
    assign head_id = head[ENTRY_W-1 -: TRF_ID_W];
    assign push = upstream_valid_in && !buf_full && !mode_enable;
    assign upstream_ready_out = mode_enable ?
        hs_drive[TRF_FORCE_UPSTREAM_READY_POS] : !buf_full;

    // Buffer write side.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            buf_mem[wr_ptr] <= {upstream_id_in, upstream_bytes_in, upstream_data_in};
        end
    end

    // Buffer pointers and occupancy.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            if (push && !pop) begin
                buf_count <= buf_count + 2'h1;
            end else if (pop && !push) begin
                buf_count <= buf_count - 2'h1;
            end
        end
    end

    // The per-output logic below is the same for both outputs.
    // A done flag stops an output from seeing the same word twice.
    // The flags clear together when the head retires.
    // An output that filters the head counts as settled at once.

    // Gather per-output inputs into vectors.
    assign port_ready = {downstream1_ready_in, downstream0_ready_in};
    assign port_force = {hs_drive[TRF_FORCE_DOWNSTREAM1_VALID_POS],
        hs_drive[TRF_FORCE_DOWNSTREAM0_VALID_POS]};

    // Per-output filtering and copy tracking.
    for (genvar p = 0; p < TRF_PORTS; p++) begin : g_port
        // The upper three ID bits select the sixteen-ID group.
        assign port_drop[p] = port_filter[p][head_id[TRF_ID_W-1 -: 3]];
        assign port_need[p] = head_valid && !port_drop[p] && !port_done[p];
        assign port_accept[p] = port_need[p] && port_ready[p] && !mode_enable;
        assign port_settled[p] = port_drop[p] || port_done[p] || port_accept[p];

        // Remembers an output that took its copy while the other still waits.
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                port_done[p] <= 1'b0;
            end else if (pop) begin
                port_done[p] <= 1'b0;
            end else if (port_accept[p]) begin
                port_done[p] <= 1'b1;
            end
        end
    end

    // The head word retires once every unfiltered output has its copy.
    assign pop = head_valid && !mode_enable && (&port_settled);

    // Downstream valid never waits on downstream ready, as the trace bus demands.
    // Once raised it holds until that output takes the word.
    // Entering integration mode or a write to that output's filter can drop it early.

    // Downstream valids are forced statically in integration mode.
    assign downstream0_valid_out = mode_enable ? port_force[0] : port_need[0];
    assign downstream1_valid_out = mode_enable ? port_force[1] : port_need[1];

    // The head fields are undefined while the matching valid is low.
    // Sinks must ignore them then.

    // Both outputs carry the buffer head word.
    assign downstream0_id_out = head_id;
    assign downstream1_id_out = head_id;
    assign downstream0_bytes_out = head[TRF_DATA_W +: TRF_BYTES_W];
    assign downstream1_bytes_out = head[TRF_DATA_W +: TRF_BYTES_W];
    assign downstream0_data_out = head[TRF_DATA_W-1:0];
    assign downstream1_data_out = head[TRF_DATA_W-1:0];

endmodule // trf_replicator
